// *** hdl/burst_slave_consts.vh ***
// Constants shared by the burst slave port and its write buffer
`ifndef BURST_SLAVE_CONSTS_VH
`define BURST_SLAVE_CONSTS_VH

`define DATA_W             32
`define BYTE_W             8
`define BE_W               4
`define ADDR_W             6
`define MEM_WORDS          64
`define BCNT_W             4
`define FIXED_READ_LATENCY 2
`define FIFO_DEPTH         16
`define FIFO_AW            4
`define FIFO_CW            5
`define WFIFO_W            42
`define WF_DATA_LO         0
`define WF_BE_LO           32
`define WF_ADDR_LO         36
`define WAIT_RST           1'b0
`define VALID_RST          1'b0
`define FLAG_RST           1'b0
`define AVAIL_RST          1'b1
`define READY_RST          1'b1

`endif

// *** hdl/wr_fifo.v ***
// Synchronous FIFO with valid/ready on both sides and an occupancy count
`timescale 1ns/1ps
module wr_fifo #(
  parameter WIDTH = 42,
  parameter DEPTH = 16,
  parameter AW    = 4
) (
  input  wire             clock_in,
  input  wire             rst_in,
  input  wire             in_valid_in,
  output wire             in_ready_out,
  input  wire [WIDTH-1:0] in_data_in,
  output wire             out_valid_out,
  input  wire             out_ready_in,
  output wire [WIDTH-1:0] out_data_out,
  output wire [AW:0]      count_out
);

  reg [WIDTH-1:0] store [0:DEPTH-1];
  reg [AW-1:0]    wr_ptr_q;
  reg [AW-1:0]    rd_ptr_q;
  reg [AW:0]      count_q;
  wire            push;
  wire            pop;

  assign in_ready_out  = (count_q != DEPTH[AW:0]);
  assign out_valid_out = (count_q != {(AW+1){1'b0}});
  assign out_data_out  = store[rd_ptr_q];
  assign count_out     = count_q;
  assign push          = in_valid_in & in_ready_out;
  assign pop           = out_valid_out & out_ready_in;

  always @(posedge clock_in)
  begin
    if (push)
    begin
      store[wr_ptr_q] <= in_data_in;
    end
  end

  always @(posedge clock_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      wr_ptr_q <= {AW{1'b0}};
      rd_ptr_q <= {AW{1'b0}};
      count_q  <= {(AW+1){1'b0}};
    end
    else
    begin
      // Pointers wrap naturally: DEPTH is a power of two
      if (push)
      begin
        wr_ptr_q <= wr_ptr_q + 1'b1;
      end
      if (pop)
      begin
        rd_ptr_q <= rd_ptr_q + 1'b1;
      end
      if (push && !pop)
      begin
        count_q <= count_q + 1'b1;
      end
      else if (pop && !push)
      begin
        count_q <= count_q - 1'b1;
      end
    end
  end

endmodule // wr_fifo

// *** hdl/burst_slave.v ***
// Pipelined burst slave port with fixed read latency and buffered write path
`timescale 1ns/1ps
`include "burst_slave_consts.vh"
module burst_slave (
  input  wire                 clock_in,
  input  wire                 rst_in,
  input  wire [`ADDR_W-1:0]   address_in,
  input  wire                 read_in,
  input  wire                 write_in,
  input  wire [`DATA_W-1:0]   writedata_in,
  input  wire [`BE_W-1:0]     byteenable_in,
  input  wire [`BCNT_W-1:0]   burstcount_in,
  input  wire                 wrap_burst_in,
  input  wire                 drain_hold_in,
  output reg                  waitrequest_out,
  output reg  [`DATA_W-1:0]   readdata_out,
  output reg                  readdatavalid_out,
  output reg                  dataavailable_out,
  output reg                  readyfordata_out
);

  localparam LAT = `FIXED_READ_LATENCY;

  // Address that follows a within a burst; wrapping stays inside the line
  function [`ADDR_W-1:0] next_addr;
    input [`ADDR_W-1:0] a;
    input [`ADDR_W-1:0] span;
    input               wrap;
    reg   [`ADDR_W-1:0] inc;
    begin
      inc = a + 1'b1;
      if (wrap)
      begin
        next_addr = (a & ~span) | (inc & span);
      end
      else
      begin
        next_addr = inc;
      end
    end
  endfunction

  // Count minus one; a count of zero is treated as a single transfer
  function [`BCNT_W-1:0] beats_left;
    input [`BCNT_W-1:0] c;
    begin
      if (c == {`BCNT_W{1'b0}})
      begin
        beats_left = {`BCNT_W{1'b0}};
      end
      else
      begin
        beats_left = c - 1'b1;
      end
    end
  endfunction

  // Expand byte enables into a bit mask over the data word
  function [`DATA_W-1:0] lane_mask;
    input [`BE_W-1:0] be;
    integer i;
    begin
      lane_mask = {`DATA_W{1'b0}};
      for (i = 0; i < `BE_W; i = i + 1)
      begin
        lane_mask[i*`BYTE_W +: `BYTE_W] = {`BYTE_W{be[i]}};
      end
    end
  endfunction

  reg  [`DATA_W-1:0]  mem [0:`MEM_WORDS-1];

  reg  [`BCNT_W-1:0]  rd_rem_q;
  reg  [`BCNT_W-1:0]  rd_rem_d;
  reg  [`ADDR_W-1:0]  rd_addr_q;
  reg  [`ADDR_W-1:0]  rd_addr_d;
  reg  [`ADDR_W-1:0]  rd_span_q;
  reg  [`ADDR_W-1:0]  rd_span_d;
  reg                 rd_wrap_q;
  reg                 rd_wrap_d;
  reg  [`BE_W-1:0]    rd_be_q;
  reg  [`BE_W-1:0]    rd_be_d;

  reg  [`BCNT_W-1:0]  wr_rem_q;
  reg  [`BCNT_W-1:0]  wr_rem_d;
  reg  [`ADDR_W-1:0]  wr_addr_q;
  reg  [`ADDR_W-1:0]  wr_addr_d;
  reg  [`ADDR_W-1:0]  wr_span_q;
  reg  [`ADDR_W-1:0]  wr_span_d;
  reg                 wr_wrap_q;
  reg                 wr_wrap_d;

  reg                 issue;
  reg  [`ADDR_W-1:0]  issue_addr;
  reg  [`BE_W-1:0]    issue_be;
  reg  [`ADDR_W-1:0]  push_addr;
  reg                 wait_d;

  // Output register is the last latency stage, so the pipe holds one less
  reg  [LAT-2:0]      pipe_v_q;
  reg  [`DATA_W-1:0]  pipe_d_q [0:LAT-2];

  wire                rd_acc;
  wire                wr_acc;
  wire                push;
  wire                fifo_in_ready;
  wire                fifo_out_valid;
  wire [`WFIFO_W-1:0] fifo_out_data;
  wire [`FIFO_CW-1:0] fifo_count;
  wire [`FIFO_CW-1:0] count_d;
  wire                pop;
  wire [`ADDR_W-1:0]  drain_addr;
  wire [`BE_W-1:0]    drain_be;
  wire [`DATA_W-1:0]  drain_data;
  wire [`DATA_W-1:0]  drain_mask;

  // Transfers are taken on any edge where waitrequest is low
  assign rd_acc = read_in & ~waitrequest_out;
  assign wr_acc = write_in & ~waitrequest_out;
  assign push   = wr_acc & fifo_in_ready;
  assign pop    = fifo_out_valid & ~drain_hold_in;

  assign count_d = fifo_count + {{(`FIFO_CW-1){1'b0}}, push} - {{(`FIFO_CW-1){1'b0}}, pop};

  assign drain_addr = fifo_out_data[`WF_ADDR_LO +: `ADDR_W];
  assign drain_be   = fifo_out_data[`WF_BE_LO +: `BE_W];
  assign drain_data = fifo_out_data[`WF_DATA_LO +: `DATA_W];
  assign drain_mask = lane_mask(drain_be);

  // Read burst engine: first beat issues on the accepting edge itself
  always @*
  begin
    rd_rem_d   = rd_rem_q;
    rd_addr_d  = rd_addr_q;
    rd_span_d  = rd_span_q;
    rd_wrap_d  = rd_wrap_q;
    rd_be_d    = rd_be_q;
    issue      = 1'b0;
    issue_addr = rd_addr_q;
    issue_be   = rd_be_q;
    if (rd_acc)
    begin
      issue      = 1'b1;
      issue_addr = address_in;
      issue_be   = byteenable_in;
      rd_rem_d   = beats_left(burstcount_in);
      rd_span_d  = {{(`ADDR_W-`BCNT_W){1'b0}}, beats_left(burstcount_in)};
      rd_wrap_d  = wrap_burst_in;
      rd_be_d    = byteenable_in;
      rd_addr_d  = next_addr(address_in, {{(`ADDR_W-`BCNT_W){1'b0}}, beats_left(burstcount_in)},
                             wrap_burst_in);
    end
    else if (rd_rem_q != {`BCNT_W{1'b0}})
    begin
      issue     = 1'b1;
      rd_rem_d  = rd_rem_q - 1'b1;
      rd_addr_d = next_addr(rd_addr_q, rd_span_q, rd_wrap_q);
    end
  end

  // Write burst tracker: count and address latched only on the first beat
  always @*
  begin
    wr_rem_d  = wr_rem_q;
    wr_addr_d = wr_addr_q;
    wr_span_d = wr_span_q;
    wr_wrap_d = wr_wrap_q;
    push_addr = wr_addr_q;
    if (push)
    begin
      if (wr_rem_q == {`BCNT_W{1'b0}})
      begin
        push_addr = address_in;
        wr_rem_d  = beats_left(burstcount_in);
        wr_span_d = {{(`ADDR_W-`BCNT_W){1'b0}}, beats_left(burstcount_in)};
        wr_wrap_d = wrap_burst_in;
        wr_addr_d = next_addr(address_in, {{(`ADDR_W-`BCNT_W){1'b0}}, beats_left(burstcount_in)},
                              wrap_burst_in);
      end
      else
      begin
        wr_rem_d  = wr_rem_q - 1'b1;
        wr_addr_d = next_addr(wr_addr_q, wr_span_q, wr_wrap_q);
      end
    end
  end

  // Registered stall: predicts the next cycle from the next state.
  // After a write burst the port stalls until the buffer drains, so a later
  // read never overtakes buffered writes to the same word.
  always @*
  begin
    wait_d = 1'b0;
    if (rd_rem_d != {`BCNT_W{1'b0}})
    begin
      wait_d = 1'b1;
    end
    if (count_d == `FIFO_DEPTH)
    begin
      wait_d = 1'b1;
    end
    if ((count_d != {`FIFO_CW{1'b0}}) && (wr_rem_d == {`BCNT_W{1'b0}}))
    begin
      wait_d = 1'b1;
    end
  end

  always @(posedge clock_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      rd_rem_q          <= {`BCNT_W{1'b0}};
      rd_addr_q         <= {`ADDR_W{1'b0}};
      rd_span_q         <= {`ADDR_W{1'b0}};
      rd_wrap_q         <= `FLAG_RST;
      rd_be_q           <= {`BE_W{1'b0}};
      wr_rem_q          <= {`BCNT_W{1'b0}};
      wr_addr_q         <= {`ADDR_W{1'b0}};
      wr_span_q         <= {`ADDR_W{1'b0}};
      wr_wrap_q         <= `FLAG_RST;
      waitrequest_out   <= `WAIT_RST;
      dataavailable_out <= `AVAIL_RST;
      readyfordata_out  <= `READY_RST;
    end
    else
    begin
      rd_rem_q          <= rd_rem_d;
      rd_addr_q         <= rd_addr_d;
      rd_span_q         <= rd_span_d;
      rd_wrap_q         <= rd_wrap_d;
      rd_be_q           <= rd_be_d;
      wr_rem_q          <= wr_rem_d;
      wr_addr_q         <= wr_addr_d;
      wr_span_q         <= wr_span_d;
      wr_wrap_q         <= wr_wrap_d;
      waitrequest_out   <= wait_d;
      // Readable only once buffered writes have landed
      dataavailable_out <= (count_d == {`FIFO_CW{1'b0}});
      readyfordata_out  <= (count_d != `FIFO_DEPTH);
    end
  end

  // Buffered writes land one per cycle, only in enabled lanes
  always @(posedge clock_in)
  begin
    if (pop)
    begin
      mem[drain_addr] <= (mem[drain_addr] & ~drain_mask) | (drain_data & drain_mask);
    end
  end

  // Fixed-depth read pipeline keeps order and exact latency
  always @(posedge clock_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      pipe_v_q[0] <= `VALID_RST;
      pipe_d_q[0] <= {`DATA_W{1'b0}};
    end
    else
    begin
      pipe_v_q[0] <= issue;
      pipe_d_q[0] <= mem[issue_addr] & lane_mask(issue_be);
    end
  end

  genvar s;
  generate
    for (s = 1; s < LAT - 1; s = s + 1)
    begin : g_stage
      always @(posedge clock_in or posedge rst_in)
      begin
        if (rst_in)
        begin
          pipe_v_q[s] <= `VALID_RST;
          pipe_d_q[s] <= {`DATA_W{1'b0}};
        end
        else
        begin
          pipe_v_q[s] <= pipe_v_q[s-1];
          pipe_d_q[s] <= pipe_d_q[s-1];
        end
      end
    end
  endgenerate

  always @(posedge clock_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      readdatavalid_out <= `VALID_RST;
      readdata_out      <= {`DATA_W{1'b0}};
    end
    else
    begin
      readdatavalid_out <= pipe_v_q[LAT-2];
      readdata_out      <= pipe_d_q[LAT-2];
    end
  end

  wr_fifo #(
    .WIDTH (`WFIFO_W),
    .DEPTH (`FIFO_DEPTH),
    .AW    (`FIFO_AW)
  ) u_wr_fifo (
    .clock_in      (clock_in),
    .rst_in        (rst_in),
    .in_valid_in   (wr_acc),
    .in_ready_out  (fifo_in_ready),
    .in_data_in    ({push_addr, byteenable_in, writedata_in}),
    .out_valid_out (fifo_out_valid),
    .out_ready_in  (~drain_hold_in),
    .out_data_out  (fifo_out_data),
    .count_out     (fifo_count)
  );

endmodule // burst_slave

// *** verif/burst_slave_asserts.sv ***
// Timing checker for the burst slave port
`timescale 1ns/1ps
`include "burst_slave_consts.vh"
module burst_slave_asserts (
  input wire               clock_in,
  input wire               rst_in,
  input wire [`ADDR_W-1:0] address_in,
  input wire               read_in,
  input wire               write_in,
  input wire [`DATA_W-1:0] writedata_in,
  input wire [`BE_W-1:0]   byteenable_in,
  input wire [`BCNT_W-1:0] burstcount_in,
  input wire               wrap_burst_in,
  input wire               drain_hold_in,
  input wire               waitrequest_out,
  input wire [`DATA_W-1:0] readdata_out,
  input wire               readdatavalid_out,
  input wire               dataavailable_out,
  input wire               readyfordata_out
);
  logic [4:0] pend_q;
  logic [4:0] pend_d;
  wire        rd_take = read_in && !waitrequest_out;
  wire  [4:0] rd_len  = (burstcount_in == 4'h0) ? 5'h1 : {1'b0, burstcount_in};
  // Words still owed to the fabric
  always @*
    pend_d = pend_q + (rd_take ? rd_len : 5'h0) - {4'h0, readdatavalid_out};
  always @(posedge clock_in or posedge rst_in)
  begin
    if (rst_in)
      pend_q <= 5'h0;
    else
      pend_q <= pend_d;
  end
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (rst_in);
  sequence single_take;
    rd_take && burstcount_in <= 4'h1;
  endsequence
  sequence stall_then_take;
    read_in && waitrequest_out ##1 single_take;
  endsequence
  valid_lat_a:
    assert property (single_take |-> ##2 readdatavalid_out) else $error("read word not at fixed latency");
  stall_take_a:
    assert property (stall_then_take |-> ##2 readdatavalid_out) else $error("stalled read mistimed");
  back_to_back_a:
    assert property (single_take |=> !waitrequest_out) else $error("next read address refused");
  burst_stall_a:
    assert property (rd_take && burstcount_in == 4'h4 |=> waitrequest_out [*3] ##1 !waitrequest_out)
      else $error("read burst stall length wrong");
  burst_beats_a:
    assert property (rd_take && burstcount_in == 4'h8 |-> ##2 readdatavalid_out [*8])
      else $error("read burst words missing");
  valid_owed_a:
    assert property (readdatavalid_out |-> pend_q != 5'h0) else $error("read word with none owed");
  rst_quiet_a:
    assert property ($fell(rst_in) |-> !readdatavalid_out && !waitrequest_out && readyfordata_out)
      else $error("outputs not idle after reset");
  ready_stall_a:
    assert property (!readyfordata_out |-> waitrequest_out) else $error("full buffer not stalling");
endmodule // burst_slave_asserts

// *** verif/fabric_model.sv ***
// Interconnect model acting for one master on the slave port
`timescale 1ns/1ps
`include "burst_slave_consts.vh"
module fabric_model (
  input  wire                clock_in,
  input  wire                waitrequest_in,
  output logic [`ADDR_W-1:0] address_out,
  output logic               read_out,
  output logic               write_out,
  output logic [`DATA_W-1:0] writedata_out,
  output logic [`BE_W-1:0]   byteenable_out,
  output logic [`BCNT_W-1:0] burstcount_out,
  output logic               wrap_out
);
  initial
  begin
    {address_out, read_out, write_out, writedata_out} = '0;
    {byteenable_out, burstcount_out, wrap_out} = '0;
  end
  // Entered at a falling edge; leaves at the falling edge after the taking edge
  task automatic issue(input logic rd, input logic [`ADDR_W-1:0] a, input logic [`DATA_W-1:0] d,
                       input logic [`BE_W-1:0] be, input logic [`BCNT_W-1:0] c, input logic w);
    read_out = rd;
    write_out = !rd;
    address_out = a;
    writedata_out = d;
    byteenable_out = be;
    burstcount_out = c;
    wrap_out = w;
    while (waitrequest_in === 1'b1)
      @(negedge clock_in);
    @(negedge clock_in);
  endtask
  // Released address, data and count lines flip, so a stale copy is never mistaken for data
  task automatic release_bus();
    read_out = 1'b0;
    write_out = 1'b0;
    address_out = ~address_out;
    writedata_out = ~writedata_out;
    burstcount_out = ~burstcount_out;
    @(negedge clock_in);
  endtask
endmodule // fabric_model

// *** verif/burst_slave_bench.sv ***
// Self-checking bench for the burst slave port
`timescale 1ns/1ps
`include "burst_slave_consts.vh"
module burst_slave_bench;
  logic               clock_in, rst_in, drain_hold, waitrequest, rvalid, avail, ready, rd_en, wr_en, wrap;
  logic [`ADDR_W-1:0] addr;
  logic [`DATA_W-1:0] wdata, rdata;
  logic [`BE_W-1:0]   be;
  logic [`BCNT_W-1:0] bcnt;
  logic [31:0]        seed = 32'h2d;
  logic [`DATA_W-1:0] mem [0:`MEM_WORDS-1];
  logic [`DATA_W-1:0] exp_q [$];
  int                 err_total = 0;
  int                 total_checks = 0;
  int                 cycles = 0;
  fabric_model u_fab (.clock_in(clock_in), .waitrequest_in(waitrequest), .address_out(addr), .read_out(rd_en),
    .write_out(wr_en), .writedata_out(wdata), .byteenable_out(be), .burstcount_out(bcnt), .wrap_out(wrap));
  burst_slave i_dut (.clock_in(clock_in), .rst_in(rst_in), .address_in(addr), .read_in(rd_en), .write_in(wr_en),
    .writedata_in(wdata), .byteenable_in(be), .burstcount_in(bcnt), .wrap_burst_in(wrap),
    .drain_hold_in(drain_hold), .waitrequest_out(waitrequest), .readdata_out(rdata),
    .readdatavalid_out(rvalid), .dataavailable_out(avail), .readyfordata_out(ready));
  initial
  begin
    clock_in = 1'b0;
    forever #10 clock_in = ~clock_in;
  end
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  function automatic logic [`DATA_W-1:0] lanes(input logic [`BE_W-1:0] b);
    for (int i = 0; i < `BE_W; i++)
      lanes[i*8 +: 8] = {8{b[i]}};
  endfunction
  function automatic logic [`ADDR_W-1:0] beat_addr(input logic [`ADDR_W-1:0] a, input int k, c, input logic w);
    logic [`ADDR_W-1:0] m;
    m = `ADDR_W'(c - 1);
    beat_addr = w ? ((a & ~m) | (`ADDR_W'(a + k) & m)) : `ADDR_W'(a + k);
  endfunction
  task automatic chk(input string what, input logic [`DATA_W-1:0] seen, exp);
    total_checks++;
    if (seen !== exp)
    begin
      err_total++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  task automatic rd(input logic [`ADDR_W-1:0] a, input int c, input logic [`BE_W-1:0] b, input logic w);
    for (int k = 0; k < c; k++)
      exp_q.push_back(mem[beat_addr(a, k, c, w)] & lanes(b));
    u_fab.issue(1'b1, a, rnd(), b, `BCNT_W'(c), w);
  endtask
  // Later beats carry junk address and count, which must be ignored
  task automatic wr(input logic [`ADDR_W-1:0] a, input int c, input logic full, input logic w);
    logic [`DATA_W-1:0] d;
    logic [`BE_W-1:0]   b;
    logic [`ADDR_W-1:0] x;
    for (int k = 0; k < c; k++)
    begin
      d = rnd();
      b = full ? 4'hf : `BE_W'(rnd());
      x = beat_addr(a, k, c, w);
      mem[x] = (mem[x] & ~lanes(b)) | (d & lanes(b));
      u_fab.issue(1'b0, k == 0 ? a : `ADDR_W'(rnd()), d, b, k == 0 ? `BCNT_W'(c) : `BCNT_W'(rnd()),
                  k == 0 ? w : 1'(rnd()));
      if (rnd() % 4 == 0)
        u_fab.release_bus();
    end
    u_fab.release_bus();
  endtask
  always @(negedge clock_in)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      err_total++;
      report_and_stop();
    end
    if (rvalid === 1'b1)
    begin
      if (exp_q.size() == 0)
        chk("spare read word", 32'h1, 32'h0);
      else
        chk("read data", rdata, exp_q.pop_front());
    end
  end
  initial
  begin
    int c;
    rst_in = 1'b1;
    drain_hold = 1'b0;
    repeat (6) @(posedge clock_in);
    @(negedge clock_in);
    rst_in = 1'b0;
    chk("idle flags", {waitrequest, rvalid, avail, ready}, 4'h3);
    @(negedge clock_in);
    for (int i = 0; i < `MEM_WORDS; i += 8)
      wr(`ADDR_W'(i), 8, 1'b1, 1'b0);
    for (int i = 0; i < 24; i++)
      rd(`ADDR_W'(rnd()), 1, `BE_W'(rnd()), 1'b0);
    for (int n = 1; n <= 8; n++)
      rd(`ADDR_W'(rnd() % (65 - n)), n, 4'hf, 1'b0);
    for (int n = 1; n <= 8; n *= 2)
      rd(`ADDR_W'(rnd()), n, `BE_W'(rnd()), 1'b1);
    rd(6'h0b, 4, 4'h1, 1'b0);
    u_fab.release_bus();
    for (int i = 0; i < 12; i++)
    begin
      c = 1 + rnd() % 8;
      wr(`ADDR_W'(rnd() % (65 - c)), c, 1'b0, 1'b0);
    end
    wr(6'h26, 8, 1'b1, 1'b1);
    drain_hold = 1'b1;
    wr(6'h10, 8, 1'b0, 1'b0);
    repeat (4) @(negedge clock_in);
    chk("buffer flags", {waitrequest, avail, ready}, 3'h5);
    drain_hold = 1'b0;
    for (int i = 0; i < `MEM_WORDS; i += 8)
      rd(`ADDR_W'(i), 8, 4'hf, 1'b0);
    u_fab.release_bus();
    repeat (20) @(negedge clock_in);
    chk("words owed", exp_q.size(), 0);
    report_and_stop();
  end
endmodule // burst_slave_bench
bind burst_slave burst_slave_asserts u_chk (.clock_in(clock_in), .rst_in(rst_in), .address_in(address_in),
  .read_in(read_in), .write_in(write_in), .writedata_in(writedata_in), .byteenable_in(byteenable_in),
  .burstcount_in(burstcount_in), .wrap_burst_in(wrap_burst_in), .drain_hold_in(drain_hold_in),
  .waitrequest_out(waitrequest_out), .readdata_out(readdata_out), .readdatavalid_out(readdatavalid_out),
  .dataavailable_out(dataavailable_out), .readyfordata_out(readyfordata_out));
